//--- inc/fpec_defines.svh
`ifndef FPEC_DEFINES_SVH
`define FPEC_DEFINES_SVH

// Register byte offsets on the APB
`define FPEC_OFS_GATE        12'h000
`define FPEC_OFS_MODE        12'h004
`define FPEC_OFS_STATUS      12'h008
`define FPEC_OFS_ERASE_SEL   12'h00c
`define FPEC_OFS_POWER       12'h010

// Mode control field positions
`define FPEC_BIT_SWE         6
`define FPEC_BIT_ESU         5
`define FPEC_BIT_PSU         4
`define FPEC_BIT_EV          3
`define FPEC_BIT_PV          2
`define FPEC_BIT_EGO         1
`define FPEC_BIT_PGO         0
`define FPEC_MODE_MASK       8'h7f

// Status, power and gate field positions
`define FPEC_BIT_ERR         7
`define FPEC_BIT_PDINH       7
`define FPEC_BIT_GATE        7

// Erase select layout
`define FPEC_ERASE_MASK      8'h1f
`define FPEC_ERASE_BLOCKS    5
`define FPEC_LARGE_BLOCK     4

// Reset values
`define FPEC_RST_REG8        8'h00

// Array geometry
`define FPEC_SMALL_BLOCK_SZ  16'h0400
`define FPEC_LARGE_BASE      16'h1000
`define FPEC_LARGE_END_32K   16'h7fff
`define FPEC_LARGE_END_16K   16'h3fff
`define FPEC_PROG_UNIT_MASK  16'hff80

`endif

//--- inc/fpec_pkg.sv
package fpec_pkg;

	// Operating mode chosen at the end of reset
	typedef enum logic [1:0] {
		FPEC_OPMODE_NONE,
		FPEC_OPMODE_USER,
		FPEC_OPMODE_BOOT
	} fpec_opmode_type;

	// Built-in loader sequence
	typedef enum logic [2:0] {
		FPEC_BOOT_IDLE,
		FPEC_BOOT_LOAD,
		FPEC_BOOT_ERASE,
		FPEC_BOOT_WAIT,
		FPEC_BOOT_RUN,
		FPEC_BOOT_FAIL
	} fpec_boot_type;

endpackage

//--- rtl/fpec_flash_control.sv
// Design decisions made here: the APB register port and the register addresses.
`include "fpec_defines.svh"
// Function
// - Program in aligned 128-byte units
// - Erase acts on whole blocks only
// - Write permission low blocks program, erase, settings
// - Erase setup bit enters erase setup state
// - Program setup bit enters program setup state
// - Erase-verify bit selects erase-verify mode
// - Program-verify bit selects program-verify mode
// - Erase go needs permission and erase setup
// - Program go needs permission and program setup
// - Error flag sets on error-protection during operation
// - Erase select held zero without permission
// - Multiple erase select bits clear all
// - Bit four targets the large block
// - Bits three to zero target 1-kbyte blocks
// - Power-down inhibit controls subactive reduced power
// - Gate bit opens the control registers
// - Reserved bits read as zero
// - Mode chosen from pins at reset end
// - Boot loads program, erases array, then runs
module fpec_flash_control #(
	parameter bit LARGE_ARRAY = 1'b1                   // 1: 32 kbyte array, 0: 16 kbyte array
) (
	input  wire logic        pclk,                     // System clock
	input  wire logic        presetn,                  // Chip reset, active low
	input  wire logic        psel,                     // APB select
	input  wire logic        penable,                  // APB access phase
	input  wire logic        pwrite,                   // APB direction
	input  wire logic [11:0] paddr,                    // APB byte address
	input  wire logic [31:0] pwdata,                   // APB write data
	output logic      [31:0] prdata,                   // APB read data
	output logic             pready,                   // APB ready
	output logic             pslverr,                  // APB error, unmapped address
	input  wire logic        test_pin,                 // Test mode pin
	input  wire logic        boot_select_pin,          // Boot select pin
	input  wire logic        boot_qualifier_pin,       // Boot qualifier pin
	input  wire logic        subactive,                // Chip is in subactive mode
	input  wire logic        array_error,              // Array reports error protection
	input  wire logic        program_addr_valid,       // CPU writes a program unit start
	input  wire logic [15:0] program_addr,             // Address of that write
	input  wire logic        loader_received,          // Serial loader finished receiving
	input  wire logic        erase_done,               // Array finished one block erase
	input  wire logic        erase_failed,             // Array could not erase
	output logic             erase_setup_state,        // Array in erase setup
	output logic             program_setup_state,      // Array in program setup
	output logic             erase_verify_mode,        // Array in erase-verify
	output logic             program_verify_mode,      // Array in program-verify
	output logic             erase_mode,               // Array erasing
	output logic             program_mode,             // Array programming
	output logic       [4:0] erase_block,              // One-hot erase target
	output logic      [15:0] erase_first,              // First address of target block
	output logic      [15:0] erase_last,               // Last address of target block
	output logic      [15:0] program_unit_base,        // Aligned program unit start
	output logic             flash_power_down,         // Reduced-power readable mode
	output fpec_pkg::fpec_opmode_type opmode,          // Mode caught at reset end
	output logic             boot_run,                 // Branch to loaded program
	output logic             boot_failed               // Loader aborted
);
	import fpec_pkg::*;

	// Number of set bits in a block select value
	function automatic logic [2:0] ones(input logic [4:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < `FPEC_ERASE_BLOCKS; i++) begin
			n = n + {2'h0, v[i]};
		end
		return n;
	endfunction

	// First address of a one-hot block select
	function automatic logic [15:0] block_first(input logic [4:0] sel);
		logic [15:0] a;
		a = 16'h0000;
		for (int i = 0; i < `FPEC_LARGE_BLOCK; i++) begin
			if (sel[i]) begin
				a = 16'(`FPEC_SMALL_BLOCK_SZ * i);
			end
		end
		if (sel[`FPEC_LARGE_BLOCK]) begin
			a = `FPEC_LARGE_BASE;
		end
		return a;
	endfunction

	// Last address of a one-hot block select
	function automatic logic [15:0] block_last(input logic [4:0] sel);
		logic [15:0] a;
		a = 16'h0000;
		for (int i = 0; i < `FPEC_LARGE_BLOCK; i++) begin
			if (sel[i]) begin
				a = 16'(`FPEC_SMALL_BLOCK_SZ * (i + 1) - 1);
			end
		end
		if (sel[`FPEC_LARGE_BLOCK]) begin
			a = LARGE_ARRAY ? `FPEC_LARGE_END_32K : `FPEC_LARGE_END_16K;
		end
		return a;
	endfunction

	// Register state
	logic        gate;                 // Control register access gate
	logic        next_gate;
	logic [6:0]  mode_bits;            // Mode control bits 6..0
	logic [6:0]  next_mode_bits;
	logic [4:0]  erase_sel;            // Erase block select
	logic [4:0]  next_erase_sel;
	logic        error_flag;           // Sticky error flag
	logic        next_error_flag;
	logic        pd_inhibit;           // Power-down inhibit
	logic        next_pd_inhibit;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	// Bus decode
	logic        setup_phase;          // First cycle of a transfer
	logic        wr_strobe;            // Write takes effect this edge
	logic        hit_gate;
	logic        hit_mode;
	logic        hit_status;
	logic        hit_erase;
	logic        hit_power;
	logic        mapped;
	logic        master_write_permission;                  // Current write permission
	logic [7:0]  wbyte;                // Low write byte

	assign setup_phase = psel & ~penable;
	assign wr_strobe   = psel & penable & pready & pwrite;
	assign hit_gate    = (paddr == `FPEC_OFS_GATE);
	assign hit_mode    = (paddr == `FPEC_OFS_MODE);
	assign hit_status  = (paddr == `FPEC_OFS_STATUS);
	assign hit_erase   = (paddr == `FPEC_OFS_ERASE_SEL);
	assign hit_power   = (paddr == `FPEC_OFS_POWER);
	assign mapped      = hit_gate | hit_mode | hit_status | hit_erase | hit_power;
	assign master_write_permission         = mode_bits[`FPEC_BIT_SWE];
	assign wbyte       = pwdata[7:0];

	// Boot loader requests
	fpec_boot_type boot_state;         // Loader step
	fpec_boot_type next_boot_state;
	logic [4:0]  boot_block;           // Block the loader is erasing
	logic [4:0]  next_boot_block;
	logic        opmode_caught;        // Pins sampled once after release
	logic        boot_erasing;         // Loader drives the array

	assign boot_erasing = (boot_state == FPEC_BOOT_WAIT);

	// Next register values and bus answer
	always_comb begin
		next_gate       = gate;
		next_mode_bits  = mode_bits;
		next_erase_sel  = erase_sel;
		next_error_flag = error_flag;
		next_pd_inhibit = pd_inhibit;
		next_prdata     = 32'h0000_0000;
		next_pready     = 1'b0;
		next_pslverr    = 1'b0;
		// Answer prepared in setup, shown in the access phase (one cycle)
		if (setup_phase) begin
			next_pready  = 1'b1;
			next_pslverr = ~mapped;
			if (!pwrite && hit_gate) begin
				next_prdata = {24'h0, gate, 7'h00};
			end else if (!pwrite && gate) begin
				if (hit_mode) begin
					next_prdata = {24'h0, 1'b0, mode_bits};
				end else if (hit_status) begin
					next_prdata = {24'h0, error_flag, 7'h00};
				end else if (hit_erase) begin
					next_prdata = {24'h0, 3'h0, erase_sel};
				end else if (hit_power) begin
					next_prdata = {24'h0, pd_inhibit, 7'h00};
				end
			end
		end
		// Writes, gated registers only while the gate is open
		if (wr_strobe) begin
			if (hit_gate) begin
				next_gate = wbyte[`FPEC_BIT_GATE];
			end else if (gate && hit_mode) begin
				// Without permission only the permission bit may change
				if (master_write_permission) begin
					next_mode_bits = wbyte[6:0];
				end else begin
					next_mode_bits = {wbyte[`FPEC_BIT_SWE], 6'h00};
				end
			end else if (gate && hit_erase && master_write_permission) begin
				// More than one block selected clears every bit
				if (ones(wbyte[4:0]) > 3'h1) begin
					next_erase_sel = 5'h00;
				end else begin
					next_erase_sel = wbyte[4:0];
				end
			end else if (gate && hit_power) begin
				next_pd_inhibit = wbyte[`FPEC_BIT_PDINH];
			end
			// Status writes are dropped: the register has no writable bit
		end
		// Permission off forces the other bits and the block select to zero
		if (!next_mode_bits[`FPEC_BIT_SWE]) begin
			next_mode_bits = 7'h00;
			next_erase_sel = 5'h00;
		end
		// Sticky error; only reset clears it
		if (array_error && (erase_mode || program_mode)) begin
			next_error_flag = 1'b1;
		end
	end

	// Register update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate       <= 1'b0;
			mode_bits  <= 7'h00;
			erase_sel  <= 5'h00;
			error_flag <= 1'b0;
			pd_inhibit <= 1'b0;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
		end else begin
			gate       <= next_gate;
			mode_bits  <= next_mode_bits;
			erase_sel  <= next_erase_sel;
			error_flag <= next_error_flag;
			pd_inhibit <= next_pd_inhibit;
			prdata     <= next_prdata;
			pready     <= next_pready;
			pslverr    <= next_pslverr;
		end
	end

	// Array controls computed from the register state
	logic        next_erase_setup_state;
	logic        next_program_setup_state;
	logic        next_erase_verify_mode;
	logic        next_program_verify_mode;
	logic        next_erase_mode;
	logic        next_program_mode;
	logic [4:0]  next_erase_block;
	logic [15:0] next_erase_first;
	logic [15:0] next_erase_last;
	logic [15:0] next_program_unit_base;
	logic        next_flash_power_down;

	// Mode decode; an error in progress drops program and register-driven erase at once, but not a loader erase
	always_comb begin
		next_erase_setup_state   = next_mode_bits[`FPEC_BIT_ESU];
		next_program_setup_state = next_mode_bits[`FPEC_BIT_PSU];
		next_erase_verify_mode   = next_mode_bits[`FPEC_BIT_EV];
		next_program_verify_mode = next_mode_bits[`FPEC_BIT_PV];
		next_erase_mode          = next_mode_bits[`FPEC_BIT_SWE] & next_mode_bits[`FPEC_BIT_ESU]
			& next_mode_bits[`FPEC_BIT_EGO] & ~next_error_flag;
		next_program_mode        = next_mode_bits[`FPEC_BIT_SWE] & next_mode_bits[`FPEC_BIT_PSU]
			& next_mode_bits[`FPEC_BIT_PGO] & ~next_error_flag;
		next_erase_block         = next_erase_sel;
		next_program_unit_base   = program_unit_base;
		// Loader owns the array while it erases
		if (boot_erasing) begin
			next_erase_mode  = 1'b1;
			next_erase_block = boot_block;
		end
		next_erase_first = block_first(next_erase_block);
		next_erase_last  = block_last(next_erase_block);
		// Unit start masked to a 128-byte boundary
		if (program_addr_valid && program_mode) begin
			next_program_unit_base = program_addr & `FPEC_PROG_UNIT_MASK;
		end
		// Reduced power only when not inhibited
		next_flash_power_down = subactive & ~next_pd_inhibit;
	end

	// Array control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_setup_state   <= 1'b0;
			program_setup_state <= 1'b0;
			erase_verify_mode   <= 1'b0;
			program_verify_mode <= 1'b0;
			erase_mode          <= 1'b0;
			program_mode        <= 1'b0;
			erase_block         <= 5'h00;
			erase_first         <= 16'h0000;
			erase_last          <= 16'h0000;
			program_unit_base   <= 16'h0000;
			flash_power_down    <= 1'b0;
		end else begin
			erase_setup_state   <= next_erase_setup_state;
			program_setup_state <= next_program_setup_state;
			erase_verify_mode   <= next_erase_verify_mode;
			program_verify_mode <= next_program_verify_mode;
			erase_mode          <= next_erase_mode;
			program_mode        <= next_program_mode;
			erase_block         <= next_erase_block;
			erase_first         <= next_erase_first;
			erase_last          <= next_erase_last;
			program_unit_base   <= next_program_unit_base;
			flash_power_down    <= next_flash_power_down;
		end
	end

	// Mode selection and loader sequence
	fpec_opmode_type next_opmode;
	logic        next_opmode_caught;
	logic        next_boot_run;
	logic        next_boot_failed;

	// Pins are caught on the first edge after release, not by the reset itself
	always_comb begin
		next_opmode        = opmode;
		next_opmode_caught = 1'b1;
		next_boot_state    = boot_state;
		next_boot_block    = boot_block;
		next_boot_run      = boot_run;
		next_boot_failed   = boot_failed;
		if (!opmode_caught) begin
			// Pins are held stable by the board around release
			if (!test_pin && boot_select_pin) begin
				next_opmode = FPEC_OPMODE_USER;
			end else if (!test_pin && boot_qualifier_pin) begin
				next_opmode = FPEC_OPMODE_BOOT;
			end else begin
				next_opmode = FPEC_OPMODE_NONE;
			end
		end
		case (boot_state)
			FPEC_BOOT_IDLE: begin
				if (opmode_caught && opmode == FPEC_OPMODE_BOOT) begin
					next_boot_state = FPEC_BOOT_LOAD;
				end
			end
			FPEC_BOOT_LOAD: begin
				// Program arrives over the serial channel into RAM
				if (loader_received) begin
					next_boot_state = FPEC_BOOT_ERASE;
					next_boot_block = 5'h01;
				end
			end
			FPEC_BOOT_ERASE: begin
				next_boot_state = FPEC_BOOT_WAIT;
			end
			FPEC_BOOT_WAIT: begin
				// One block at a time, last one is the large block
				if (erase_failed) begin
					next_boot_state  = FPEC_BOOT_FAIL;
					next_boot_failed = 1'b1;
				end else if (erase_done) begin
					if (boot_block[`FPEC_LARGE_BLOCK]) begin
						next_boot_state = FPEC_BOOT_RUN;
						next_boot_block = 5'h00;
						next_boot_run   = 1'b1;
					end else begin
						next_boot_state = FPEC_BOOT_ERASE;
						next_boot_block = {boot_block[3:0], 1'b0};
					end
				end
			end
			FPEC_BOOT_RUN: begin
				next_boot_run = 1'b1;
			end
			FPEC_BOOT_FAIL: begin
				next_boot_failed = 1'b1;
			end
			default: begin
				next_boot_state = FPEC_BOOT_IDLE;
			end
		endcase
	end

	// Mode and loader registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opmode        <= FPEC_OPMODE_NONE;
			opmode_caught <= 1'b0;
			boot_state    <= FPEC_BOOT_IDLE;
			boot_block    <= 5'h00;
			boot_run      <= 1'b0;
			boot_failed   <= 1'b0;
		end else begin
			opmode        <= next_opmode;
			opmode_caught <= next_opmode_caught;
			boot_state    <= next_boot_state;
			boot_block    <= next_boot_block;
			boot_run      <= next_boot_run;
			boot_failed   <= next_boot_failed;
		end
	end

endmodule

//--- sim/fpec_flash_control_chk.sv
module fpec_flash_control_chk #(
	parameter bit LARGE_ARRAY = 1'b1                   // Array size, as in the design
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        test_pin,
	input wire logic        boot_select_pin,
	input wire logic        boot_qualifier_pin,
	input wire logic        subactive,
	input wire logic        array_error,
	input wire logic        erase_setup_state,
	input wire logic        program_setup_state,
	input wire logic        erase_mode,
	input wire logic        program_mode,
	input wire logic [4:0]  erase_block,
	input wire logic [15:0] erase_first,
	input wire logic [15:0] erase_last,
	input wire logic [15:0] program_unit_base,
	input wire logic        flash_power_down,
	input wire fpec_pkg::fpec_opmode_type opmode,
	input wire logic        boot_run
);
	timeunit 1ns;
	timeprecision 1ns;
	import fpec_pkg::*;
	// End of the large block depends on the array size
	localparam logic [15:0] LAST = LARGE_ARRAY ? 16'h7fff : 16'h3fff;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_unit_align: assert property (program_unit_base[6:0] == 7'h00)
		else $error("program unit base not aligned");
	chk_block_onehot: assert property ($onehot0(erase_block))
		else $error("erase target not one-hot");
	chk_large_bounds: assert property (erase_block == 5'h10 |-> erase_first == 16'h1000 && erase_last == LAST)
		else $error("large block bounds wrong");
	chk_small_bounds: assert property (erase_block[3:0] != 4'h0 |-> erase_last == erase_first + 16'h03ff
		&& erase_first == {4'h0, erase_block[3] | erase_block[2], erase_block[3] | erase_block[1], 10'h000})
		else $error("small block bounds wrong");
	chk_erase_gated: assert property (erase_mode && opmode != FPEC_OPMODE_BOOT |-> erase_setup_state)
		else $error("erase mode without erase setup");
	chk_prog_gated: assert property (program_mode |-> program_setup_state)
		else $error("program mode without program setup");
	chk_error_stop: assert property ((erase_mode || program_mode) && array_error |=> !erase_mode && !program_mode)
		else $error("operation kept running after error");
	chk_power_stay: assert property (!subactive |=> !flash_power_down)
		else $error("power down outside subactive");
	chk_reserved_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	// Pins are caught once, at the first edge after release
	chk_mode_pick: assert property ($past(presetn) && !$past(presetn, 2) |-> opmode ==
		(!$past(test_pin) && $past(boot_select_pin) ? FPEC_OPMODE_USER :
		!$past(test_pin) && $past(boot_qualifier_pin) ? FPEC_OPMODE_BOOT : FPEC_OPMODE_NONE))
		else $error("operating mode wrongly decoded");
	chk_mode_hold: assert property ($past(presetn) && presetn |=> $stable(opmode))
		else $error("operating mode changed after reset");
	cov_erase: cover property (erase_mode);
	cov_program: cover property (program_mode);
	cov_boot_run: cover property ($rose(boot_run));
endmodule

bind fpec_flash_control fpec_flash_control_chk #(.LARGE_ARRAY(LARGE_ARRAY)) u_fpec_flash_control_chk (
	.pclk(pclk), .presetn(presetn), .pwrite(pwrite), .pready(pready), .prdata(prdata),
	.test_pin(test_pin), .boot_select_pin(boot_select_pin), .boot_qualifier_pin(boot_qualifier_pin),
	.subactive(subactive), .array_error(array_error), .erase_setup_state(erase_setup_state),
	.program_setup_state(program_setup_state), .erase_mode(erase_mode), .program_mode(program_mode),
	.erase_block(erase_block), .erase_first(erase_first), .erase_last(erase_last),
	.program_unit_base(program_unit_base), .flash_power_down(flash_power_down), .opmode(opmode),
	.boot_run(boot_run));

//--- sim/fpec_flash_control_test.sv
`include "fpec_defines.svh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module fpec_flash_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	import fpec_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0;           // Clock and active-low reset
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic        pready, pslverr;
	logic        test_pin = 1'b0, boot_select_pin = 1'b1, boot_qualifier_pin = 1'b0;
	logic        subactive = 1'b0, array_error = 1'b0, program_addr_valid = 1'b0;
	logic [15:0] program_addr = 16'h0000, program_unit_base;
	logic        loader_received = 1'b0, erase_done = 1'b0, boot_run, flash_power_down;
	logic        erase_failed = 1'b0, boot_failed;            // Loader abort stimulus and flag
	logic        erase_setup_state, program_setup_state, erase_verify_mode, program_verify_mode;
	logic        erase_mode, program_mode;
	logic [4:0]  erase_block, b;
	fpec_opmode_type opmode;
	logic [32:0] expq [$];                               // Expected {error, data} per read
	logic [32:0] rexp;
	logic [13:0] tab [10];                               // {mode write, six mode outputs}
	int          n_fail = 0, comparisons = 0, i, n;
	fpec_flash_control u_fpec_flash_control (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.test_pin(test_pin), .boot_select_pin(boot_select_pin), .boot_qualifier_pin(boot_qualifier_pin),
		.subactive(subactive), .array_error(array_error), .program_addr_valid(program_addr_valid),
		.program_addr(program_addr), .loader_received(loader_received), .erase_done(erase_done),
		.erase_failed(erase_failed), .erase_setup_state(erase_setup_state),
		.program_setup_state(program_setup_state),
		.erase_verify_mode(erase_verify_mode), .program_verify_mode(program_verify_mode),
		.erase_mode(erase_mode), .program_mode(program_mode), .erase_block(erase_block),
		.erase_first(), .erase_last(), .program_unit_base(program_unit_base),
		.flash_power_down(flash_power_down), .opmode(opmode), .boot_run(boot_run), .boot_failed(boot_failed));
	// 50 MHz clock
	always #10 pclk = ~pclk;
	// One APB transfer; a read leaves its expectation for the monitor
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		if (!w) begin
			expq.push_back(e);
		end
		@(posedge pclk);
		penable <= 1'b1;
		// Held until pready is seen; the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 33'h000000000);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] d);
		apb(1'b0, a, 8'h00, {25'h0000000, d});
	endtask
	// Mode outputs looked at mid-cycle, once settled
	task automatic outs(input logic [5:0] e);
		@(negedge pclk);
		`CHK("mode outputs", e, {erase_setup_state, program_setup_state, erase_verify_mode,
			program_verify_mode, erase_mode, program_mode})
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Monitor: each completed read takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			rexp = expq.pop_front();
			`CHK("read data", rexp[31:0], prdata)
			`CHK("slave error", rexp[32], pslverr)
		end
	end
	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		stop_test();
	end
	initial begin
		tab = '{{8'h60, 6'h20}, {8'h62, 6'h22}, {8'h60, 6'h20}, {8'h48, 6'h08}, {8'h44, 6'h04},
			{8'h50, 6'h10}, {8'h51, 6'h11}, {8'h41, 6'h00}, {8'h42, 6'h00}, {8'h40, 6'h00}};
		void'($urandom(23092));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(negedge pclk);
		`CHK("opmode", FPEC_OPMODE_USER, opmode)
		wr(`FPEC_OFS_MODE, 8'h40);
		rd(`FPEC_OFS_MODE, 8'h00);
		wr(`FPEC_OFS_GATE, 8'hff);
		rd(`FPEC_OFS_GATE, 8'h80);
		wr(`FPEC_OFS_MODE, 8'h3f);
		rd(`FPEC_OFS_MODE, 8'h00);
		wr(`FPEC_OFS_ERASE_SEL, 8'h01);
		rd(`FPEC_OFS_ERASE_SEL, 8'h00);
		apb(1'b0, 12'h020, 8'h00, {1'b1, 32'h00000000});
		done("gating");
		wr(`FPEC_OFS_MODE, 8'h40);
		b = 5'h01 << ($urandom % 5);
		wr(`FPEC_OFS_ERASE_SEL, {3'b000, b});
		rd(`FPEC_OFS_ERASE_SEL, {3'b000, b});
		@(negedge pclk);
		`CHK("erase block", b, erase_block)
		wr(`FPEC_OFS_ERASE_SEL, 8'h11);
		rd(`FPEC_OFS_ERASE_SEL, 8'h00);
		done("erase select");
		// Each step sets at most one new mode bit
		for (i = 0; i < 10; i++) begin
			wr(`FPEC_OFS_MODE, tab[i][13:6]);
			rd(`FPEC_OFS_MODE, tab[i][13:6]);
			outs(tab[i][5:0]);
		end
		done("modes");
		wr(`FPEC_OFS_MODE, 8'h50);
		wr(`FPEC_OFS_MODE, 8'h51);
		@(posedge pclk);
		program_addr <= 16'($urandom);
		program_addr_valid <= 1'b1;
		@(posedge pclk);
		program_addr_valid <= 1'b0;
		@(negedge pclk);
		`CHK("unit base", program_addr & 16'hff80, program_unit_base)
		@(posedge pclk);
		array_error <= 1'b1;
		@(posedge pclk);
		array_error <= 1'b0;
		@(negedge pclk);
		`CHK("program mode", 1'b0, program_mode)
		rd(`FPEC_OFS_STATUS, 8'h80);
		wr(`FPEC_OFS_STATUS, 8'h00);
		rd(`FPEC_OFS_STATUS, 8'h80);
		done("error");
		wr(`FPEC_OFS_POWER, 8'hff);
		rd(`FPEC_OFS_POWER, 8'h80);
		@(posedge pclk);
		subactive <= 1'b1;
		repeat (2) @(negedge pclk);
		`CHK("power down", 1'b0, flash_power_down)
		wr(`FPEC_OFS_POWER, 8'h00);
		repeat (2) @(negedge pclk);
		`CHK("power down", 1'b1, flash_power_down)
		done("power");
		wr(`FPEC_OFS_MODE, 8'h40);
		wr(`FPEC_OFS_ERASE_SEL, 8'h02);
		wr(`FPEC_OFS_MODE, 8'h00);
		rd(`FPEC_OFS_ERASE_SEL, 8'h00);
		wr(`FPEC_OFS_GATE, 8'h00);
		wr(`FPEC_OFS_POWER, 8'h80);
		wr(`FPEC_OFS_GATE, 8'h80);
		rd(`FPEC_OFS_POWER, 8'h00);
		done("permission");
		// Second reset into the loader
		@(posedge pclk);
		presetn <= 1'b0;
		boot_select_pin <= 1'b0;
		boot_qualifier_pin <= 1'b1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(negedge pclk);
		`CHK("opmode", FPEC_OPMODE_BOOT, opmode)
		// Loader input changes on the rising edge like every other input
		@(posedge pclk);
		loader_received <= 1'b1;
		for (i = 0; i < 5; i++) begin
			n = 0;
			while (erase_mode !== 1'b1 && n < 100) begin
				@(negedge pclk);
				n++;
			end
			repeat (2) @(negedge pclk);
			`CHK("boot block", 5'h01 << i, erase_block)
			@(posedge pclk);
			erase_done <= 1'b1;
			@(posedge pclk);
			erase_done <= 1'b0;
			repeat (2) @(negedge pclk);
		end
		repeat (2) @(negedge pclk);
		`CHK("boot run", 1'b1, boot_run)
		done("boot");
		// Third reset: a failed erase must stop the loader short of the branch
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		n = 0;
		while (erase_mode !== 1'b1 && n < 100) begin
			@(negedge pclk);
			n++;
		end
		@(posedge pclk);
		erase_failed <= 1'b1;
		@(posedge pclk);
		erase_failed <= 1'b0;
		repeat (2) @(negedge pclk);
		`CHK("boot failed", 1'b1, boot_failed)
		`CHK("boot run", 1'b0, boot_run)
		done("boot fail");
		stop_test();
	end
endmodule
